// ---- core/rtmrw_pkg.sv ----
package rtmrw_pkg;
    // message information word field positions
    localparam int GAP_ERR_BIT   = 13;
    localparam int WC_ERR_BIT    = 12;
    localparam int MSG_ERR_BIT   = 10;
    localparam int BUSY_BIT      = 9;
    localparam int ILL_CMD_BIT   = 8;
    localparam int TERMINAL_TO_TERMINAL_FLAG_BIT      = 6;
    localparam int BUS_SEL_BIT   = 5;
    localparam int WC_MSB        = 4;
    // record word offsets from the data pointer
    localparam logic [14:0] OFS_INFO = 15'h0000;
    localparam logic [14:0] OFS_TAG  = 15'h0001;
    localparam logic [14:0] OFS_DATA = 15'h0002;
    // mode code split: codes at or above carry one data word
    localparam logic [4:0] MC_DATA_FIRST = 5'h10;
    // undefined receive mode codes with data
    localparam logic [4:0] MC_UNDEF_A = 5'h10;
    localparam logic [4:0] MC_UNDEF_B = 5'h12;
    localparam logic [4:0] MC_UNDEF_C = 5'h13;
    // record writer states
    typedef enum logic [3:0] {
        RTMRW_IDLE = 4'b0001,
        RTMRW_INFO = 4'b0010,
        RTMRW_TAG  = 4'b0100,
        RTMRW_DATA = 4'b1000
    } rtmrw_state_t;
endpackage

// ---- core/rtmrw_writer.sv ----
`timescale 1ns/1ps
module rtmrw_writer
    import rtmrw_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // message completion from the decoder
    input  wire logic        msg_done,
    input  wire logic        msg_is_mode,
    input  wire logic        msg_is_tx,
    input  wire logic [4:0]  msg_count,
    input  wire logic [14:0] data_pointer,
    input  wire logic [15:0] time_tag,
    input  wire logic [15:0] mode_data,
    input  wire logic        gap_seen,
    input  wire logic        extra_words,
    input  wire logic        global_busy,
    input  wire logic        force_busy_control,
    input  wire logic        illegal_entry,
    input  wire logic        terminal_to_terminal_flag_ok,
    input  wire logic        bus_b,
    input  wire logic        undefined_mode_code_invalid,
    // response decision
    output logic             in_form_r,
    output logic             send_data_r,
    // shared ram write port
    output logic             ram_we_r,
    output logic [14:0]      ram_addr_r,
    output logic [15:0]      ram_wdata_r,
    output logic             busy_r
);
    rtmrw_state_t state_r, state_nxt;
    logic [15:0] info_r, info_nxt;
    logic [15:0] tag_r, tag_nxt;
    logic [15:0] mdata_r, mdata_nxt;
    logic [14:0] ptr_r, ptr_nxt;
    logic        has_data_r, has_data_nxt;
    logic        we_nxt;
    logic [14:0] addr_nxt;
    logic [15:0] wdata_nxt;
    logic        in_form_nxt, send_nxt;
    logic        gap_e, wc_e, bsy, undef_rx;

    // error and busy terms for the arriving message
    assign gap_e = gap_seen & msg_is_tx;
    assign wc_e  = extra_words & msg_is_tx;
    assign bsy   = (global_busy | force_busy_control) & msg_is_tx;
    assign undef_rx = msg_is_mode & ~msg_is_tx &
        (msg_count < MC_DATA_FIRST || msg_count == MC_UNDEF_A ||
         msg_count == MC_UNDEF_B || msg_count == MC_UNDEF_C);

    // next state and record capture
    always_comb begin
        state_nxt    = state_r;
        info_nxt     = info_r;
        tag_nxt      = tag_r;
        mdata_nxt    = mdata_r;
        ptr_nxt      = ptr_r;
        has_data_nxt = has_data_r;
        we_nxt       = 1'b0;
        addr_nxt     = ram_addr_r;
        wdata_nxt    = ram_wdata_r;
        in_form_nxt  = in_form_r;
        send_nxt     = send_data_r;
        unique case (state_r)
            RTMRW_IDLE: begin
                if (msg_done) begin
                    info_nxt = 16'h0000;
                    info_nxt[GAP_ERR_BIT] = gap_e;
                    info_nxt[WC_ERR_BIT]  = wc_e;
                    info_nxt[MSG_ERR_BIT] = gap_e | wc_e;
                    info_nxt[BUSY_BIT]    = bsy;
                    info_nxt[ILL_CMD_BIT] = illegal_entry;
                    info_nxt[TERMINAL_TO_TERMINAL_FLAG_BIT] = terminal_to_terminal_flag_ok & msg_is_tx &
                        ~msg_is_mode & ~(gap_e | wc_e);
                    info_nxt[BUS_SEL_BIT] = bus_b;
                    info_nxt[WC_MSB:0]    = msg_count;
                    tag_nxt   = time_tag;
                    mdata_nxt = mode_data;
                    ptr_nxt   = data_pointer;
                    // only receive mode data is stored here
                    has_data_nxt = msg_is_mode & ~msg_is_tx &
                        (msg_count >= MC_DATA_FIRST);
                    in_form_nxt = ~(undef_rx &
                        (illegal_entry | undefined_mode_code_invalid))
                        & ~illegal_entry;
                    send_nxt = msg_is_tx & ~bsy;
                    state_nxt = RTMRW_INFO;
                end
            end
            RTMRW_INFO: begin
                we_nxt    = 1'b1;
                addr_nxt  = ptr_r + OFS_INFO;
                wdata_nxt = info_r;
                state_nxt = RTMRW_TAG;
            end
            RTMRW_TAG: begin
                we_nxt    = 1'b1;
                addr_nxt  = ptr_r + OFS_TAG;
                wdata_nxt = tag_r;
                state_nxt = has_data_r ? RTMRW_DATA : RTMRW_IDLE;
            end
            RTMRW_DATA: begin
                we_nxt    = 1'b1;
                addr_nxt  = ptr_r + OFS_DATA;
                wdata_nxt = mdata_r;
                state_nxt = RTMRW_IDLE;
            end
            default: state_nxt = RTMRW_IDLE;
        endcase
    end

    // register all state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= RTMRW_IDLE;
            info_r      <= 16'h0000;
            tag_r       <= 16'h0000;
            mdata_r     <= 16'h0000;
            ptr_r       <= 15'h0000;
            has_data_r  <= 1'b0;
            ram_we_r    <= 1'b0;
            ram_addr_r  <= 15'h0000;
            ram_wdata_r <= 16'h0000;
            in_form_r   <= 1'b1;
            send_data_r <= 1'b0;
            busy_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            info_r      <= info_nxt;
            tag_r       <= tag_nxt;
            mdata_r     <= mdata_nxt;
            ptr_r       <= ptr_nxt;
            has_data_r  <= has_data_nxt;
            ram_we_r    <= we_nxt;
            ram_addr_r  <= addr_nxt;
            ram_wdata_r <= wdata_nxt;
            in_form_r   <= in_form_nxt;
            send_data_r <= send_nxt;
            busy_r      <= (state_nxt != RTMRW_IDLE);
        end
    end

    // record checks: a taken message is counted from its msg_done edge;
    // the info word shows two cycles later, the tag three, mode data four

    // info word written two cycles after completion
    info_write_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2 ram_we_r &&
        ram_addr_r == $past(data_pointer, 2))
        else $error("info word not written at pointer");

    // tag write follows the info write at the next address
    tag_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        ram_we_r && state_r == RTMRW_TAG |=> ram_we_r &&
        ram_addr_r == $past(ram_addr_r) + 15'h0001)
        else $error("time tag not at pointer plus one");

    // unused info bits leave as zero
    unused_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RTMRW_INFO |=> ram_wdata_r[15:14] == 2'b00 &&
        !ram_wdata_r[11] && !ram_wdata_r[7])
        else $error("unused info bits not zero");

    // message error is exactly the or of its two causes
    message_error_flag_or_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RTMRW_INFO |=> ram_wdata_r[MSG_ERR_BIT] ==
        (ram_wdata_r[GAP_ERR_BIT] | ram_wdata_r[WC_ERR_BIT]))
        else $error("message error not tied to causes");

    // global busy blocks the data words
    busy_nodata_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_tx &&
        global_busy |=> !send_data_r)
        else $error("data sent while busy");

    // per-command force busy blocks the data words too
    force_nodata_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_tx &&
        force_busy_control |=> !send_data_r)
        else $error("data sent under forced busy");

    // mode codes without data close after the tag
    nodata_mode_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_mode &&
        msg_count < MC_DATA_FIRST |-> ##4 !ram_we_r)
        else $error("extra word stored for mode without data");

    // receive mode data lands as the third word
    mode_data_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_mode && !msg_is_tx &&
        msg_count >= MC_DATA_FIRST |-> ##4 ram_we_r &&
        ram_wdata_r == $past(mode_data, 4))
        else $error("mode data word not stored");

    // receive mode data address is pointer plus two
    data_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_mode && !msg_is_tx &&
        msg_count >= MC_DATA_FIRST |-> ##4
        ram_addr_r == $past(data_pointer, 4) + OFS_DATA)
        else $error("mode data word at wrong address");

    // undefined receive codes refused when the config bit is set
    undef_inform_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && undef_rx &&
        undefined_mode_code_invalid |=> !in_form_r)
        else $error("undefined mode code answered in form");

    // an illegal entry always refuses the in-form answer
    ill_inform_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE &&
        illegal_entry |=> !in_form_r)
        else $error("illegal command answered in form");

    // with no entry and no config bit every receive mode code is in form
    defined_inform_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_mode && !msg_is_tx &&
        !illegal_entry && !undefined_mode_code_invalid |=> in_form_r)
        else $error("receive mode code refused without cause");

    // bus select follows the bus used
    bus_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[BUS_SEL_BIT] == $past(bus_b, 2))
        else $error("bus select bit wrong");

    // gap error only from a transmit message
    gap_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[GAP_ERR_BIT] ==
        ($past(gap_seen, 2) && $past(msg_is_tx, 2)))
        else $error("gap error bit wrong");

    // word count error only from a transmit message
    wc_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[WC_ERR_BIT] ==
        ($past(extra_words, 2) && $past(msg_is_tx, 2)))
        else $error("word count error bit wrong");

    // busy response bit from either busy source
    busy_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[BUSY_BIT] == (($past(global_busy, 2) ||
        $past(force_busy_control, 2)) && $past(msg_is_tx, 2)))
        else $error("busy response bit wrong");

    // illegal command bit copies the table entry
    ill_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[ILL_CMD_BIT] == $past(illegal_entry, 2))
        else $error("illegal command bit wrong");

    // word count field copies the command field
    count_field_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[WC_MSB:0] == $past(msg_count, 2))
        else $error("word count field wrong");

    // terminal to terminal bit only for a clean transmit subaddress
    terminal_to_terminal_flag_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##2
        ram_wdata_r[TERMINAL_TO_TERMINAL_FLAG_BIT] == ($past(terminal_to_terminal_flag_ok, 2) &&
        $past(msg_is_tx, 2) && !$past(msg_is_mode, 2) &&
        !$past(gap_seen, 2) && !$past(extra_words, 2)))
        else $error("terminal to terminal bit wrong");

    // receive records carry no transmit error or busy flags
    rx_noerr_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && !msg_is_tx |-> ##2
        !ram_wdata_r[MSG_ERR_BIT] && !ram_wdata_r[BUSY_BIT])
        else $error("error flag on receive record");

    // time tag word lands at pointer plus one with the captured tag
    tag_word_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |-> ##3 ram_we_r &&
        ram_addr_r == $past(data_pointer, 3) + OFS_TAG &&
        ram_wdata_r == $past(time_tag, 3))
        else $error("time tag word wrong");

    // transmit records never touch the host's data words
    tx_nostore_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE && msg_is_tx |-> ##4
        !ram_we_r)
        else $error("device wrote over transmit data");

    // busy stands from the cycle after msg_done and drops as the last word is written
    busy_span_a: assert property (@(posedge clk) disable iff (!resetn)
        msg_done && state_r == RTMRW_IDLE |=> busy_r ##1 busy_r)
        else $error("busy dropped during record");

    // main scenarios
    tx_rec_c: cover property (@(posedge clk) msg_done && msg_is_tx);
    mode_rx_c: cover property (@(posedge clk) state_r == RTMRW_DATA);
    busy_c: cover property (@(posedge clk) msg_done && bsy);
    undef_c: cover property (@(posedge clk) msg_done && undef_rx);
    tx_mode_c: cover property (@(posedge clk)
        msg_done && msg_is_tx && msg_is_mode);
endmodule // rtmrw_writer

// ---- dv/rtmrw_ram_model.sv ----
`timescale 1ns/1ps
// shared ram behind the writer; the host side preloads transmit data
module rtmrw_ram_model (
    // clock
    input wire logic        clk,
    // write port from the record writer
    input wire logic        ram_we_r,
    input wire logic [14:0] ram_addr_r,
    input wire logic [15:0] ram_wdata_r
);
    logic [15:0] mem [0:32767];
    int          wr_count = 0;
    // store every device write and count it
    always @(posedge clk) begin
        if (ram_we_r) begin
            mem[ram_addr_r] <= ram_wdata_r;
            wr_count <= wr_count + 1;
        end
    end
    // host data goes past the two words left for the device
    task automatic host_fill(input logic [14:0] ptr, input logic [15:0] w);
        mem[ptr + 15'h0002] = w;
    endtask
endmodule // rtmrw_ram_model

// ---- dv/rt_message_record_writer_tb.sv ----
`timescale 1ns/1ps
module rt_message_record_writer_tb;
    import rtmrw_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, msg_done = 1'b0, msg_is_mode = 1'b0;
    logic msg_is_tx = 1'b0, gap_seen = 1'b0, extra_words = 1'b0;
    logic global_busy = 1'b0, force_busy_control = 1'b0, terminal_to_terminal_flag_ok = 1'b0;
    logic illegal_entry = 1'b0, bus_b = 1'b0, undefined_mode_code_invalid = 1'b0;
    logic [4:0]  msg_count = 5'h00;
    logic [14:0] data_pointer = 15'h04f0;
    logic [15:0] time_tag = 16'h0000, mode_data = 16'h0000, ram_wdata_r;
    logic        in_form_r, send_data_r, ram_we_r, busy_r;
    logic [14:0] ram_addr_r;
    int          bad_count = 0, checks_done = 0, cycles = 0;
    always #2.5 clk = ~clk;
    rtmrw_writer dut (.clk, .resetn, .msg_done, .msg_is_mode, .msg_is_tx,
        .msg_count, .data_pointer, .time_tag, .mode_data, .gap_seen,
        .extra_words, .global_busy, .force_busy_control, .illegal_entry,
        .terminal_to_terminal_flag_ok, .bus_b, .undefined_mode_code_invalid, .in_form_r,
        .send_data_r, .ram_we_r, .ram_addr_r, .ram_wdata_r, .busy_r);
    rtmrw_ram_model ram (.clk, .ram_we_r, .ram_addr_r, .ram_wdata_r);
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    // one message: fresh record, pulse done, wait for the record to close
    task automatic send(input logic md, tx, input logic [4:0] cnt,
                        input logic [6:0] fl, input logic umc, output int nw);
        int n;
        @(posedge clk);
        #1;
        n = ram.wr_count;
        {gap_seen, extra_words, global_busy, force_busy_control} = fl[6:3];
        {illegal_entry, terminal_to_terminal_flag_ok, bus_b} = fl[2:0];
        msg_is_mode = md;
        msg_is_tx = tx;
        msg_count = cnt;
        undefined_mode_code_invalid = umc;
        time_tag = time_tag + 16'h0101;
        mode_data = ~time_tag;
        data_pointer = data_pointer + 15'h0010;
        ram.host_fill(data_pointer, 16'h5a5a);
        msg_done = 1'b1;
        @(posedge clk);
        #1;
        msg_done = 1'b0;
        for (int i = 0; i < 8 && busy_r === 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        nw = ram.wr_count - n;
    endtask
    // transmit subaddress records over flag combinations
    task automatic t_tx();
        logic [6:0]  fl [7] = '{7'h00, 7'h42, 7'h20, 7'h10, 7'h08, 7'h04, 7'h03};
        logic [15:0] e;
        logic [4:0]  c;
        int          nw;
        for (int i = 0; i < 7; i++) begin
            c = 5'(i * 11);
            send(1'b0, 1'b1, c, fl[i], 1'b0, nw);
            e = {2'b00, fl[i][6], fl[i][5], 1'b0, fl[i][6] | fl[i][5],
                 fl[i][4] | fl[i][3], fl[i][2], 1'b0,
                 fl[i][1] & ~fl[i][6] & ~fl[i][5], fl[i][0], c};
            check(ram.mem[data_pointer + OFS_INFO], e);
            check(ram.mem[data_pointer + OFS_TAG], time_tag);
            check(ram.mem[data_pointer + OFS_DATA], 16'h5a5a);
            check(16'(nw), 16'h0002);
            if (!fl[i][2])
                check({15'h0, send_data_r}, {15'h0, ~(fl[i][4] | fl[i][3])});
        end
    endtask
    // every receive mode code, with and without the undefined-code bit
    task automatic t_rx_mode();
        logic und;
        int   nw;
        for (int u = 0; u < 2; u++)
            for (int c = 0; c < 32; c++) begin
                send(1'b1, 1'b0, 5'(c), {6'h00, c[0]}, u[0], nw);
                und = c < 17 || c == 18 || c == 19;
                check({15'h0, in_form_r}, {15'h0, ~(und & u[0])});
                check(ram.mem[data_pointer] & 16'h013f, {10'h0, c[0], 5'(c)});
                check(ram.mem[data_pointer + OFS_TAG], time_tag);
                check(ram.mem[data_pointer + OFS_DATA],
                      c > 15 ? mode_data : 16'h5a5a);
                check(16'(nw), c > 15 ? 16'h0003 : 16'h0002);
            end
        send(1'b1, 1'b0, 5'h12, 7'h04, 1'b0, nw); // entry set on purpose
        check({15'h0, in_form_r}, 16'h0000);
        check(ram.mem[data_pointer] & 16'h0100, 16'h0100);
    endtask
    // transmit mode commands: gap flagged, terminal_to_terminal_flag held off, busy blocks data
    task automatic t_tx_mode();
        int nw;
        send(1'b1, 1'b1, 5'h02, 7'h43, 1'b0, nw);
        check(ram.mem[data_pointer + OFS_INFO], 16'h2422);
        check(16'(nw), 16'h0002);
        send(1'b1, 1'b1, 5'h11, 7'h08, 1'b0, nw);
        check(ram.mem[data_pointer + OFS_INFO], 16'h0211);
        check(ram.mem[data_pointer + OFS_DATA], 16'h5a5a);
        check({15'h0, send_data_r}, 16'h0000);
        check(16'(nw), 16'h0002);
    endtask
    // reset in mid-run returns outputs to their reset values
    task automatic t_reset();
        @(posedge clk);
        #1;
        resetn = 1'b0;
        @(posedge clk);
        #1;
        check({12'h0, in_form_r, send_data_r, busy_r, ram_we_r}, 16'h0008);
        resetn = 1'b1;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check({14'h0, in_form_r, busy_r}, 16'h0002);
        resetn = 1'b1;
        t_tx();
        t_reset();
        t_tx_mode();
        t_rx_mode();
        give_verdict();
    end
endmodule // rt_message_record_writer_tb
